// file: core/scm_pkg.sv
package scm_pkg;

  // phase argument and lookup address
  localparam int PHASE_W   = 32;
  localparam int ADDR_W    = 20;
  localparam int ADDR_LSB  = PHASE_W - ADDR_W;
  localparam int QUAD_W    = 2;
  localparam int HALF_W    = 16;

  // sine/cosine generator
  localparam int TRIG_W    = 16;
  localparam int GUARD_W   = 3;
  localparam int CX_W      = TRIG_W + GUARD_W + 2;
  localparam int ANG_W     = 24;
  localparam int ANG_PAD   = ANG_W - ADDR_W;
  localparam int CZ_W      = ANG_W + 1;
  localparam int MAX_STAGES = 20;
  // cordic start value: gain-compensated full scale with guard bits
  localparam logic signed [CX_W-1:0] CORDIC_X0 = 21'sh026DCF;
  localparam logic signed [TRIG_W-1:0] TRIG_POS_FS = 16'sh7FFF;
  localparam logic signed [TRIG_W-1:0] TRIG_NEG_FS = 16'sh8001;
  // arctangent of 2^-i, 2^24 units per turn
  localparam logic [ANG_W-1:0] ATAN_TAB [0:MAX_STAGES-1] = '{
    24'h200000, 24'h12E405, 24'h09FB34, 24'h051111, 24'h028B0D,
    24'h0145D8, 24'h00A2F6, 24'h00517C, 24'h0028BE, 24'h00145F,
    24'h000A30, 24'h000518, 24'h00028C, 24'h000146, 24'h0000A3,
    24'h000051, 24'h000029, 24'h000014, 24'h00000A, 24'h000005};

  // datapath widths
  localparam int IN_W      = 19;
  localparam int PROD_W    = 33;
  localparam int ACC_W     = 35;
  localparam int OUT_W     = 20;
  localparam int OUT_HI_LSB = 31;
  localparam int OUT_MID_LSB = 15;
  localparam int OUT_LO_W  = 15;

  // apb register map
  localparam int APB_AW    = 12;
  localparam logic [APB_AW-1:0] REG_CTRL     = 12'h000;
  localparam logic [APB_AW-1:0] REG_STATUS   = 12'h004;
  localparam logic [APB_AW-1:0] REG_REAL_OUT = 12'h008;
  localparam logic [APB_AW-1:0] REG_IMAG_OUT = 12'h00C;
  localparam logic [7:0]        CTRL_RESET   = 8'hC1;
  localparam int CTRL_BYPASS_N = 0;
  localparam int CTRL_FEEDBACK = 1;
  localparam int CTRL_SCALE_LSB = 2;
  localparam int CTRL_OSEL_LSB = 4;
  localparam int CTRL_OFFBIN_N = 6;
  localparam int CTRL_HOLD_N   = 7;
  localparam int STAT_CNT_LSB  = 4;

  typedef enum logic [1:0] {
    SCM_OSEL_MSB   = 2'b00,
    SCM_OSEL_LSB   = 2'b01,
    SCM_OSEL_AUX   = 2'b10,
    SCM_OSEL_RSVD  = 2'b11
  } scm_osel_t;

endpackage

// file: core/scm_sincos_complex_multiply_accumulate.sv
// Function
// - a 32-bit phase argument is taken every clock as the phase input
// - upper 20 phase bits address the generator, giving 16-bit sine and cosine
// - the 20-bit address spans one turn, zero is zero radians
// - sine and cosine are two's complement limited to 8001..7FFF
// - vector error stays below -90.2 dB, components about 2 dB better
// - bypass low routes the phase itself to the multiplier operands
// - bypass readback: upper phase half on imag_out, lower on real_out
// - real = cos*re - sin*im, imag = cos*im + sin*re
// - inputs latch only on clocks where input_latch_enable_n is low
// - scale select picks a 16-bit slice of the latched inputs
// - 33-bit products are registered before accumulation
// - feedback enable accumulates, otherwise the product alone is stored
// - output select chooses msb view, lsb view, auxiliary sum, or reserved
// - offset binary select low inverts output bit 19
// - auxiliary accumulator sums the shifted inputs into 20 bits
// - growth_code reports 0 to 3 bits of growth above unity
// - hold low keeps the largest growth code seen
// - inputs carry point after top bit, outputs after fifth top bit

module scm_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // write side
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  // read side
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  // fill level
  output logic [$clog2(D+1)-1:0]      count
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] DEPTH = CW'(D);

  if (D < 2 || W < 1) begin : g_chk
    $error("scm_fifo: depth must be at least 2");
  end

  logic [W-1:0]  mem [0:D-1];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic          ready_r;
  logic          empty_r;
  logic          push;
  logic          pop;

  assign push      = in_valid & ready_r;
  assign pop       = out_ready & ~empty_r;
  assign in_ready  = ready_r;
  assign out_valid = ~empty_r;
  assign out_data  = mem[rd_ptr_r];
  assign count     = count_r;

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + CW'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - CW'(1);
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(D - 1)) ? '0 : wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(D - 1)) ? '0 : rd_ptr_r + PW'(1);
      end
    end
  end

  // flags registered so the ready seen upstream comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
      ready_r <= 1'b1;
      empty_r <= 1'b1;
    end else begin
      count_r <= count_nxt;
      ready_r <= (count_nxt != DEPTH);
      empty_r <= (count_nxt == '0);
    end
  end
endmodule

module scm_sincos_complex_multiply_accumulate #(
  parameter int CORDIC_STAGES = scm_pkg::MAX_STAGES,
  parameter int FIFO_DEPTH    = 8
) (
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [scm_pkg::APB_AW-1:0]     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  // phase argument from the phase/frequency control section
  input  wire logic [scm_pkg::PHASE_W-1:0]    phase_in,
  // sample stream
  input  wire logic                           sample_valid,
  output logic                                sample_ready,
  input  wire logic [scm_pkg::IN_W-1:0]       real_in,
  input  wire logic [scm_pkg::IN_W-1:0]       imag_in,
  input  wire logic                           input_latch_enable_n,
  // results
  output logic [scm_pkg::OUT_W-1:0]           real_out,
  output logic [scm_pkg::OUT_W-1:0]           imag_out,
  output logic                                out_valid,
  output logic [1:0]                          growth_code
);
  import scm_pkg::*;

  localparam int N  = CORDIC_STAGES;
  localparam int FW = 2 * IN_W;
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  if (N < 16 || N > MAX_STAGES) begin : g_chk
    $error("scm_sincos_complex_multiply_accumulate: CORDIC_STAGES out of range");
  end

  // control register fields
  logic [7:0]         ctrl_r;
  logic               sincos_bypass_n;
  logic               sum_feedback_enable;
  logic [1:0]         input_scale_select;
  scm_osel_t          output_select;
  logic               offset_binary_select_n;
  logic               max_growth_hold_n;

  assign sincos_bypass_n        = ctrl_r[CTRL_BYPASS_N];
  assign sum_feedback_enable    = ctrl_r[CTRL_FEEDBACK];
  assign input_scale_select     = ctrl_r[CTRL_SCALE_LSB +: 2];
  assign output_select          = scm_osel_t'(ctrl_r[CTRL_OSEL_LSB +: 2]);
  assign offset_binary_select_n = ctrl_r[CTRL_OFFBIN_N];
  assign max_growth_hold_n      = ctrl_r[CTRL_HOLD_N];

  // input fifo
  logic              fifo_valid;
  logic [FW-1:0]     fifo_data;
  logic [CW-1:0]     fifo_count;
  logic              latch;

  assign latch = fifo_valid & ~input_latch_enable_n;

  scm_fifo #(.W(FW), .D(FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   ({real_in, imag_in}),
    .out_valid (fifo_valid),
    .out_ready (~input_latch_enable_n),
    .out_data  (fifo_data),
    .count     (fifo_count)
  );

  // sine/cosine generator: pipelined rotation over one quadrant
  logic signed [CX_W-1:0]   cx  [0:N];
  logic signed [CX_W-1:0]   cy  [0:N];
  logic signed [CZ_W-1:0]   cz  [0:N];
  logic [PHASE_W-1:0]       cph [0:N];
  logic signed [TRIG_W-1:0] cos_r;
  logic signed [TRIG_W-1:0] sin_r;
  logic signed [TRIG_W-1:0] xs;
  logic signed [TRIG_W-1:0] ys;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cx[0]  <= '0;
      cy[0]  <= '0;
      cz[0]  <= '0;
      cph[0] <= '0;
    end else begin
      cx[0]  <= CORDIC_X0;
      cy[0]  <= '0;
      cz[0]  <= $signed({{(QUAD_W + 1){1'b0}}, phase_in[ADDR_LSB +: ADDR_W - QUAD_W],
                         {ANG_PAD{1'b0}}});
      cph[0] <= phase_in;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_stage
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cx[i+1]  <= '0;
        cy[i+1]  <= '0;
        cz[i+1]  <= '0;
        cph[i+1] <= '0;
      end else begin
        if (!cz[i][CZ_W-1]) begin
          cx[i+1] <= cx[i] - (cy[i] >>> i);
          cy[i+1] <= cy[i] + (cx[i] >>> i);
          cz[i+1] <= cz[i] - $signed({1'b0, ATAN_TAB[i]});
        end else begin
          cx[i+1] <= cx[i] + (cy[i] >>> i);
          cy[i+1] <= cy[i] - (cx[i] >>> i);
          cz[i+1] <= cz[i] + $signed({1'b0, ATAN_TAB[i]});
        end
        cph[i+1] <= cph[i];
      end
    end
  end

  // round away the guard bits and clamp to the symmetric range
  function automatic logic signed [TRIG_W-1:0] trig_sat(input logic signed [CX_W-1:0] v);
    logic signed [CX_W-1:0] r;
    r = (v + $signed(CX_W'(1 << (GUARD_W - 1)))) >>> GUARD_W;
    if (r > CX_W'(TRIG_POS_FS)) begin
      trig_sat = TRIG_POS_FS;
    end else if (r < CX_W'(TRIG_NEG_FS)) begin
      trig_sat = TRIG_NEG_FS;
    end else begin
      trig_sat = r[TRIG_W-1:0];
    end
  endfunction

  assign xs = trig_sat(cx[N]);
  assign ys = trig_sat(cy[N]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cos_r <= '0;
      sin_r <= '0;
    end else if (!sincos_bypass_n) begin
      cos_r <= cph[N][HALF_W-1:0];
      sin_r <= cph[N][PHASE_W-1 -: HALF_W];
    end else begin
      // quadrant unfolding; negation is safe since 8000 never occurs
      case (cph[N][PHASE_W-1 -: QUAD_W])
        2'b00: begin
          cos_r <= xs;
          sin_r <= ys;
        end
        2'b01: begin
          cos_r <= -ys;
          sin_r <= xs;
        end
        2'b10: begin
          cos_r <= -xs;
          sin_r <= -ys;
        end
        default: begin
          cos_r <= ys;
          sin_r <= -xs;
        end
      endcase
    end
  end

  // input registers and shifters
  logic [IN_W-1:0]          in_re_r;
  logic [IN_W-1:0]          in_im_r;
  logic [IN_W-1:0]          re_sh;
  logic [IN_W-1:0]          im_sh;
  logic signed [TRIG_W-1:0] re_sl;
  logic signed [TRIG_W-1:0] im_sl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_re_r <= '0;
      in_im_r <= '0;
    end else if (latch) begin
      in_re_r <= fifo_data[FW-1 -: IN_W];
      in_im_r <= fifo_data[IN_W-1:0];
    end
  end

  assign re_sh = in_re_r >> input_scale_select;
  assign im_sh = in_im_r >> input_scale_select;
  assign re_sl = re_sh[TRIG_W-1:0];
  assign im_sl = im_sh[TRIG_W-1:0];

  // complex multiplier with registered products
  logic signed [2*TRIG_W-1:0] p_cr;
  logic signed [2*TRIG_W-1:0] p_si;
  logic signed [2*TRIG_W-1:0] p_ci;
  logic signed [2*TRIG_W-1:0] p_sr;
  logic signed [PROD_W-1:0]   mre_r;
  logic signed [PROD_W-1:0]   mim_r;
  logic signed [OUT_W-1:0]    aux_in_re_r;
  logic signed [OUT_W-1:0]    aux_in_im_r;
  logic [2:0]                 vld_r;

  assign p_cr = cos_r * re_sl;
  assign p_si = sin_r * im_sl;
  assign p_ci = cos_r * im_sl;
  assign p_sr = sin_r * re_sl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mre_r       <= '0;
      mim_r       <= '0;
      aux_in_re_r <= '0;
      aux_in_im_r <= '0;
    end else begin
      mre_r <= {p_cr[2*TRIG_W-1], p_cr} - {p_si[2*TRIG_W-1], p_si};
      mim_r <= {p_ci[2*TRIG_W-1], p_ci} + {p_sr[2*TRIG_W-1], p_sr};
      // input point after top bit lands after fifth top bit
      aux_in_re_r <= {{(OUT_W - TRIG_W){re_sl[TRIG_W-1]}}, re_sl};
      aux_in_im_r <= {{(OUT_W - TRIG_W){im_sl[TRIG_W-1]}}, im_sl};
    end
  end

  // accumulators
  logic signed [ACC_W-1:0] acc_re_r;
  logic signed [ACC_W-1:0] acc_im_r;
  logic signed [OUT_W-1:0] aux_re_r;
  logic signed [OUT_W-1:0] aux_im_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_re_r <= '0;
      acc_im_r <= '0;
    end else begin
      acc_re_r <= (sum_feedback_enable ? acc_re_r : '0) + ACC_W'(mre_r);
      acc_im_r <= (sum_feedback_enable ? acc_im_r : '0) + ACC_W'(mim_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_re_r <= '0;
      aux_im_r <= '0;
    end else begin
      aux_re_r <= (sum_feedback_enable ? aux_re_r : '0) + aux_in_re_r;
      aux_im_r <= (sum_feedback_enable ? aux_im_r : '0) + aux_in_im_r;
    end
  end

  // output multiplexer and format
  function automatic logic [OUT_W-1:0] out_sel(input scm_osel_t sel,
                                               input logic [ACC_W-1:0] a,
                                               input logic [OUT_W-1:0] x,
                                               input logic offbin_n);
    logic [OUT_W-1:0] v;
    case (sel)
      SCM_OSEL_MSB:  v = a[ACC_W-1:OUT_MID_LSB];
      SCM_OSEL_LSB:  v = {a[ACC_W-1:OUT_HI_LSB], 1'b0, a[OUT_LO_W-1:0]};
      SCM_OSEL_AUX:  v = x;
      default:       v = '0;
    endcase
    v[OUT_W-1] = v[OUT_W-1] ^ ~offbin_n;
    out_sel = v;
  endfunction

  // growth above unity of a value with four integer bits over the sign
  function automatic logic [1:0] grow(input logic [OUT_W-1:0] v);
    if (&v[OUT_W-1:OUT_MID_LSB] || ~|v[OUT_W-1:OUT_MID_LSB]) begin
      grow = 2'b00;
    end else if (&v[OUT_W-1:OUT_MID_LSB+1] || ~|v[OUT_W-1:OUT_MID_LSB+1]) begin
      grow = 2'b01;
    end else if (&v[OUT_W-1:OUT_MID_LSB+2] || ~|v[OUT_W-1:OUT_MID_LSB+2]) begin
      grow = 2'b10;
    end else begin
      grow = 2'b11;
    end
  endfunction

  logic [1:0] g_a;
  logic [1:0] g_b;
  logic [1:0] g_c;
  logic [1:0] g_d;
  logic [1:0] g_now;

  always_comb begin
    g_a   = grow(acc_re_r[ACC_W-1:OUT_MID_LSB]);
    g_b   = grow(acc_im_r[ACC_W-1:OUT_MID_LSB]);
    g_c   = grow(aux_re_r);
    g_d   = grow(aux_im_r);
    g_now = g_a;
    if (g_b > g_now) begin
      g_now = g_b;
    end
    if (g_c > g_now) begin
      g_now = g_c;
    end
    if (g_d > g_now) begin
      g_now = g_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      real_out <= '0;
      imag_out <= '0;
    end else begin
      real_out <= out_sel(output_select, acc_re_r, aux_re_r, offset_binary_select_n);
      imag_out <= out_sel(output_select, acc_im_r, aux_im_r, offset_binary_select_n);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      growth_code <= 2'b00;
    end else if (!max_growth_hold_n) begin
      growth_code <= (g_now > growth_code) ? g_now : growth_code;
    end else begin
      growth_code <= g_now;
    end
  end

  // marks the output produced by a latched sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vld_r     <= '0;
      out_valid <= 1'b0;
    end else begin
      vld_r     <= {vld_r[1:0], latch};
      out_valid <= vld_r[2];
    end
  end

  // apb slave, one wait state
  logic acc_phase;
  logic mapped;

  assign acc_phase = psel & penable;

  always_comb begin
    if (paddr == REG_CTRL) begin
      mapped = 1'b1;
    end else if (paddr == REG_STATUS) begin
      mapped = ~pwrite;
    end else if (paddr == REG_REAL_OUT) begin
      mapped = ~pwrite;
    end else if (paddr == REG_IMAG_OUT) begin
      mapped = ~pwrite;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc_phase & ~pready;
      pslverr <= acc_phase & ~pready & ~mapped;
      if (acc_phase && !pready && !pwrite) begin
        if (paddr == REG_CTRL) begin
          prdata <= 32'(ctrl_r);
        end else if (paddr == REG_STATUS) begin
          prdata <= 32'({fifo_count, 2'b00, growth_code});
        end else if (paddr == REG_REAL_OUT) begin
          prdata <= 32'(real_out);
        end else if (paddr == REG_IMAG_OUT) begin
          prdata <= 32'(imag_out);
        end else begin
          prdata <= '0;
        end
      end else begin
        prdata <= '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (acc_phase && pready && pwrite && paddr == REG_CTRL) begin
      ctrl_r <= pwdata[7:0];
    end
  end
endmodule

// file: testbench/scm_complex_multiply_accumulate_properties.sv
module scm_complex_multiply_accumulate_props (
  // clock and reset
  input wire logic                          pclk,
  input wire logic                          presetn,
  // apb
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [scm_pkg::APB_AW-1:0]    paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  // stream and results
  input wire logic                          sample_valid,
  input wire logic                          sample_ready,
  input wire logic                          input_latch_enable_n,
  input wire logic [scm_pkg::OUT_W-1:0]     real_out,
  input wire logic [scm_pkg::OUT_W-1:0]     imag_out,
  input wire logic                          out_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  import scm_pkg::*;

  logic [7:0] ctrl_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // shadow of the control register, updated on the completing edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_q <= CTRL_RESET;
    else if (psel && penable && pready && pwrite && paddr == REG_CTRL)
      ctrl_q <= pwdata[7:0];
  end

  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside the answer cycle");
  chk_refuse_bad: assert property (psel && penable && !pready && (paddr > REG_IMAG_OUT
      || paddr[1:0] != 2'b00 || (pwrite && paddr != REG_CTRL)) |=> pslverr)
    else $error("bad access not refused");
  chk_valid_cause: assert property (out_valid |-> $past(input_latch_enable_n, 4) == 1'b0)
    else $error("result marked without a latch four edges before");
  chk_ready_fall: assert property ($fell(sample_ready) |-> $past(sample_valid))
    else $error("sample_ready fell without a push");
  chk_sel_reserved: assert property (ctrl_q[5:4] == 2'b11 |=>
      real_out == {~$past(ctrl_q[6]), 19'h0} && imag_out == {~$past(ctrl_q[6]), 19'h0})
    else $error("reserved select output wrong");
endmodule

bind scm_sincos_complex_multiply_accumulate scm_complex_multiply_accumulate_props u_scm_complex_multiply_accumulate_props (
  .pclk                 (pclk),
  .presetn              (presetn),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .paddr                (paddr),
  .pwdata               (pwdata),
  .prdata               (prdata),
  .pready               (pready),
  .pslverr              (pslverr),
  .sample_valid         (sample_valid),
  .sample_ready         (sample_ready),
  .input_latch_enable_n (input_latch_enable_n),
  .real_out             (real_out),
  .imag_out             (imag_out),
  .out_valid            (out_valid)
);

// file: testbench/scm_sample_src.sv
module scm_sample_src (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // stream toward the block
  output logic                            sample_valid,
  input  wire logic                       sample_ready,
  output logic [scm_pkg::IN_W-1:0]        real_in,
  output logic [scm_pkg::IN_W-1:0]        imag_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import scm_pkg::*;

  logic [2*IN_W-1:0] q[$];

  task automatic push(input logic [IN_W-1:0] re, input logic [IN_W-1:0] im);
    q.push_back({re, im});
  endtask

  // word held until taken; idle lines toggle so stale data is never mistaken for valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_valid <= 1'b0;
      real_in <= '0;
      imag_in <= '0;
    end else begin
      if (sample_valid && sample_ready)
        void'(q.pop_front());
      if (q.size() > 0) begin
        sample_valid <= 1'b1;
        {real_in, imag_in} <= q[0];
      end else begin
        sample_valid <= 1'b0;
        {real_in, imag_in} <= ~{real_in, imag_in};
      end
    end
  end
endmodule

// file: testbench/sincos_complex_mac_test.sv
module sincos_complex_mac_test;
  timeunit 1ns;
  timeprecision 100ps;
  import scm_pkg::*;

  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [APB_AW-1:0]   paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [PHASE_W-1:0]  phase_in;
  logic                sample_valid;
  logic                sample_ready;
  logic [IN_W-1:0]     real_in;
  logic [IN_W-1:0]     imag_in;
  logic                input_latch_enable_n;
  logic [OUT_W-1:0]    real_out;
  logic [OUT_W-1:0]    imag_out;
  logic                out_valid;
  logic [1:0]          growth_code;
  logic [31:0]         rd_data;
  logic                rd_err;
  logic [31:0]         ph;
  real                 a;
  int                  err_count;
  int                  tests_run;
  int                  valid_seen;
  logic [31:0] ph_tab [5] = '{32'h0, 32'h20000000, 32'h40000000, 32'h80000000, 32'hC0000FFF};
  logic [31:0] bp_tab [2] = '{32'hC000FFF0, 32'h40001234};

  scm_sincos_complex_multiply_accumulate #(.CORDIC_STAGES(20), .FIFO_DEPTH(8)) u_scm_sincos_complex_multiply_accumulate (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_in(phase_in), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .real_in(real_in), .imag_in(imag_in), .input_latch_enable_n(input_latch_enable_n),
    .real_out(real_out), .imag_out(imag_out), .out_valid(out_valid),
    .growth_code(growth_code));

  scm_sample_src u_scm_sample_src (
    .pclk(pclk), .presetn(presetn), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .real_in(real_in), .imag_in(imag_in));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // one result mark per latched sample
  always @(posedge pclk) begin
    if (out_valid === 1'b1)
      valid_seen <= valid_seen + 1;
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp, input int tol);
    logic signed [19:0] d;
    d = seen - exp;
    tests_run++;
    if (seen !== exp && (tol == 0 || ^seen === 1'bx || d > tol || d < -tol)) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [APB_AW-1:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // product with a 7FFF operand, as the msb or lsb view shows it
  function automatic logic [19:0] mulq(input longint op, input int osel);
    longint p;
    p = op * 32767;
    if (osel == 1)
      return {p[34:31], 1'b0, p[14:0]};
    return 20'(p >>> 15);
  endfunction

  function automatic logic [19:0] aux(input logic [18:0] v, input int s);
    logic [15:0] t;
    t = 16'(v >> s);
    return {{4{t[15]}}, t};
  endfunction

  // phase path is 25 edges deep, so 30 always settles
  task automatic settle;
    repeat (30) @(posedge pclk);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge pclk);
    err_count++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    phase_in = '0;
    input_latch_enable_n = 1'b0;
    err_count = 0;
    tests_run = 0;
    valid_seen = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd_data[19:0], 20'hC1, 0);
    apb(1'b0, 12'h010, 32'h0);
    check({19'h0, rd_err}, 20'h1, 0);
    apb(1'b1, REG_STATUS, 32'hFF);
    check({19'h0, rd_err}, 20'h1, 0);
    u_scm_sample_src.push(19'h07FFF, 19'h0);
    for (int i = 0; i < 5; i++) begin
      ph = ph_tab[i];
      phase_in <= ph;
      settle();
      a = 6.283185307179586 * real'(ph[31:12]) / 1048576.0;
      check(real_out, mulq($rtoi(32767.0 * $cos(a)), 0), 3);
      check(imag_out, mulq($rtoi(32767.0 * $sin(a)), 0), 3);
    end
    for (int o = 0; o < 2; o++) begin
      for (int i = 0; i < 2; i++) begin
        ph = bp_tab[i];
        apb(1'b1, REG_CTRL, 32'hC0 | (o << 4));
        phase_in <= ph;
        settle();
        check(real_out, mulq(longint'($signed(ph[15:0])), o), 0);
        check(imag_out, mulq(longint'($signed(ph[31:16])), o), 0);
        apb(1'b0, REG_IMAG_OUT, 32'h0);
        check(rd_data[19:0], mulq(longint'($signed(ph[31:16])), o), 0);
      end
    end
    u_scm_sample_src.push(19'h5ABCD, 19'h3C3A5);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, REG_CTRL, 32'hE1 | (s << 2));
      settle();
      check(real_out, aux(19'h5ABCD, s), 0);
      check(imag_out, aux(19'h3C3A5, s), 0);
    end
    apb(1'b1, REG_CTRL, 32'hA1);
    settle();
    check(real_out, aux(19'h5ABCD, 0) ^ 20'h80000, 0);
    apb(1'b1, REG_CTRL, 32'hB1);
    settle();
    check(imag_out, 20'h80000, 0);
    apb(1'b1, REG_CTRL, 32'hF1);
    settle();
    check(real_out, 20'h0, 0);
    apb(1'b1, REG_CTRL, 32'hE1);
    input_latch_enable_n <= 1'b1;
    for (int k = 1; k < 10; k++)
      u_scm_sample_src.push(19'(k * 256), 19'(k));
    settle();
    check({19'h0, sample_ready}, 20'h0, 0);
    check(real_out, aux(19'h5ABCD, 0), 0);
    apb(1'b0, REG_STATUS, 32'h0);
    check({16'h0, rd_data[7:4]}, 20'h8, 0);
    input_latch_enable_n <= 1'b0;
    settle();
    check(real_out, 20'h00900, 0);
    check(imag_out, 20'h00009, 0);
    u_scm_sample_src.push(19'h04000, 19'h0);
    phase_in <= 32'h0;
    apb(1'b1, REG_CTRL, 32'h63);
    repeat (100) @(posedge pclk);
    check({18'h0, growth_code}, 20'h3, 0);
    apb(1'b1, REG_CTRL, 32'h61);
    settle();
    check({18'h0, growth_code}, 20'h3, 0);
    check(real_out, 20'h04000, 0);
    apb(1'b1, REG_CTRL, 32'hE1);
    settle();
    check({18'h0, growth_code}, 20'h0, 0);
    check(20'(valid_seen), 20'hC, 0);
    summarize();
  end
endmodule
